// ### hw/push_home_ctrl.sv
`timescale 1ns/100ps
// Summary of operation
// - push moves at entry speed, no ramp
// - contact sets push flag, ready, push current
// - no contact: stop, complete, ready, push current
// - stop input halts move, push or seek with stop current
// - push faster than 30 r/min raises alarm
// - ready drops on motion start, start handshake
// - linked then push runs as one sequence
// - 3-sensor homing stops at home sensor
// - 2-sensor reverses, backs off 200 steps
// - push homing reverses off stop, 200 steps
// - back-off counted in raw steps
// - preset load sets position, no motion
// - offset move after homing sets home
// - homing completion zeroes command position
// - optional sensor_input_a or timing qualification
// - mode 0/1/2 selects homing, default 1
// - home done asserted on completion
module push_home_ctrl
    import motion_pkg::*;
(
    input  wire logic             clock,           // core clock
    input  wire logic             nrst,            // sync reset, low
    input  wire logic [SEL_W-1:0] data_select_inputs, // entry number
    input  wire logic             start,           // start entry
    input  wire logic             home_start,      // start homing
    input  wire logic             stop_in,         // stop request
    input  wire logic             position_load_input, // preset load
    input  wire logic [1:0]       entry_func,      // selected function
    input  wire logic [1:0]       next_func,       // following entry func
    input  wire logic [SPD_W-1:0] entry_speed,     // selected speed
    input  wire logic [SPD_W-1:0] next_speed,      // following speed
    input  wire logic [POS_W-1:0] entry_dist,      // selected distance
    input  wire logic [POS_W-1:0] next_dist,       // following distance
    input  wire logic             entry_dir,       // selected direction
    input  wire logic [CUR_W-1:0] push_current,    // push current set
    input  wire logic [CUR_W-1:0] run_current,     // running current
    input  wire logic [CUR_W-1:0] stop_current,    // standstill current
    input  wire logic [15:0]      steps_per_rev,   // resolution
    input  wire logic             load_contact,    // load/stall detect
    input  wire logic [1:0]       home_mode,       // homing method
    input  wire logic [SPD_W-1:0] home_run_speed,  // seek operating speed
    input  wire logic [SPD_W-1:0] home_start_speed, // seek start speed
    input  wire logic [POS_W-1:0] home_offset,     // signed offset
    input  wire logic             home_dir,        // start direction
    input  wire logic             sensor_input_a_enable,     // use sensor_input_a
    input  wire logic             tim_enable,      // use timing_signal
    input  wire logic [POS_W-1:0] preset_position, // preset value
    input  wire logic             home_sensor,     // home sensor
    input  wire logic             limit_pos,       // + limit sensor
    input  wire logic             limit_neg,       // - limit sensor
    input  wire logic             sensor_input_a,  // external sensor_input_a
    input  wire logic             timing_signal,   // timing signal
    output logic                  ready,           // ready for start
    output logic                  push_contact_flag, // push status
    output logic                  op_complete_output, // op ended
    output logic                  home_done_output,   // homing done
    output logic                  data_error_alarm,   // data alarm
    output logic                  step_out,        // step pulse
    output logic                  dir_out,         // 1 = positive
    output logic [CUR_W-1:0]      motor_current,   // current set
    output logic [POS_W-1:0]      command_position, // position
    output logic [SEL_W-1:0]      active_entry     // running entry
);

    // ------------------------------------------------------------------
    // states
    // ------------------------------------------------------------------
    typedef enum logic [7:0] {
        ST_IDLE   = 8'h01,  // stopped, waiting
        ST_MOVE   = 8'h02,  // linked or single move
        ST_PUSH   = 8'h04,  // constant speed push
        ST_SEEK   = 8'h08,  // homing seek
        ST_BACK   = 8'h10,  // reversal / 200-step back-off
        ST_QUAL   = 8'h20,  // wait for sensor_input_a / timing
        ST_OFFSET = 8'h40,  // home offset move
        ST_HOLD   = 8'h80   // wait for start release
    } state_t;

    state_t             state_q;     // sequencer state
    logic [POS_W-1:0]   remain_q;    // steps left in move
    logic [SPD_W-1:0]   speed_q;     // current step rate
    logic [8:0]         backoff_q;   // back-off step counter
    logic               cleared_q;   // sensor cleared in back-off
    logic               step_en;     // step enable from generator
    logic               running;     // generator run
    logic               qual_ok;     // external qualifiers met
    logic [31:0]        push_cap;    // push speed cap in steps/s
    logic               seek_hit;    // seek termination event
    logic               abs_neg;     // offset sign

    assign running  = (state_q != ST_IDLE) && (state_q != ST_HOLD)
                      && (state_q != ST_QUAL || !qual_ok);
    // 30 r/min in steps per second at the set steps_per_rev
    assign push_cap = 32'(steps_per_rev) * 32'(PUSH_MAX_RPM)
                      / 32'(SECS_PER_MIN);
    // sensor_input_a and/or timing must accompany home detection
    assign qual_ok  = (!sensor_input_a_enable || sensor_input_a)
                      && (!tim_enable || timing_signal);
    assign abs_neg  = home_offset[POS_W-1];

    // seek end per homing mode
    always_comb
    begin
        case (home_mode)
            HOME_MODE_2SENSOR: seek_hit = limit_pos | limit_neg;
            HOME_MODE_PUSH:    seek_hit = load_contact;
            default:           seek_hit = home_sensor;
        endcase
    end

    step_rate_gen u_rate (
        .clock   (clock),
        .nrst    (nrst),
        .run     (running),
        .rate_hz (speed_q),
        .step_en (step_en)
    );

    // ------------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!nrst)
        begin
            state_q            <= ST_IDLE;
            remain_q           <= '0;
            speed_q            <= '0;
            backoff_q          <= '0;
            cleared_q          <= 1'b0;
            ready              <= 1'b1;
            push_contact_flag  <= 1'b0;
            op_complete_output <= 1'b0;
            home_done_output   <= 1'b0;
            data_error_alarm   <= 1'b0;
            dir_out            <= 1'b1;
            motor_current      <= '0;
            active_entry       <= '0;
        end
        else
        begin
            case (state_q)
                // wait for a start, homing or preset request
                ST_IDLE:
                begin
                    if (start && ready)
                    begin
                        push_contact_flag  <= 1'b0;
                        op_complete_output <= 1'b0;
                        active_entry       <= data_select_inputs;
                        dir_out            <= entry_dir;
                        if (entry_func == FUNC_PUSH &&
                            32'(entry_speed) > push_cap)
                        begin
                            data_error_alarm <= 1'b1;
                            state_q          <= ST_HOLD;
                        end
                        else
                        begin
                            ready         <= 1'b0;
                            remain_q      <= entry_dist;
                            speed_q       <= entry_speed;
                            motor_current <= run_current;
                            state_q <= (entry_func == FUNC_PUSH)
                                       ? ST_PUSH : ST_MOVE;
                        end
                    end
                    else if (home_start && ready)
                    begin
                        ready              <= 1'b0;
                        home_done_output   <= 1'b0;
                        push_contact_flag  <= 1'b0;
                        op_complete_output <= 1'b0;
                        dir_out            <= home_dir;
                        motor_current      <= run_current;
                        speed_q <= (home_mode == HOME_MODE_3SENSOR)
                                   ? home_run_speed
                                   : home_start_speed;
                        state_q <= ST_SEEK;
                    end
                end
                // ordinary move; linked push continues without stop
                ST_MOVE:
                begin
                    if (stop_in)
                    begin
                        op_complete_output <= 1'b1;
                        motor_current      <= stop_current;
                        state_q            <= ST_HOLD;
                    end
                    else if (remain_q == '0)
                    begin
                        if (entry_func == FUNC_LINKED &&
                            next_func == FUNC_PUSH)
                        begin
                            if (32'(next_speed) > push_cap)
                            begin
                                data_error_alarm <= 1'b1;
                                state_q          <= ST_HOLD;
                            end
                            else
                            begin
                                remain_q <= next_dist;
                                speed_q  <= next_speed;
                                state_q  <= ST_PUSH;
                            end
                        end
                        else
                        begin
                            op_complete_output <= 1'b1;
                            motor_current      <= stop_current;
                            state_q            <= ST_HOLD;
                        end
                    end
                    else if (step_en)
                        remain_q <= remain_q - 1'b1;
                end
                // constant speed push, no ramp
                ST_PUSH:
                begin
                    if (stop_in)
                    begin
                        op_complete_output <= 1'b1;
                        motor_current      <= stop_current;
                        state_q            <= ST_HOLD;
                    end
                    else if (load_contact)
                    begin
                        push_contact_flag <= 1'b1;
                        motor_current     <= push_current;
                        state_q           <= ST_HOLD;
                    end
                    else if (remain_q == '0)
                    begin
                        op_complete_output <= 1'b1;
                        motor_current      <= push_current;
                        state_q            <= ST_HOLD;
                    end
                    else if (step_en)
                        remain_q <= remain_q - 1'b1;
                end
                // seek for home sensor, limit or stopper
                ST_SEEK:
                begin
                    if (stop_in)
                    begin
                        motor_current <= stop_current;
                        state_q       <= ST_HOLD;
                    end
                    else if (seek_hit)
                    begin
                        if (home_mode == HOME_MODE_3SENSOR)
                            state_q <= ST_QUAL;
                        else
                        begin
                            dir_out   <= ~dir_out;
                            backoff_q <= '0;
                            cleared_q <= (home_mode == HOME_MODE_PUSH);
                            state_q   <= ST_BACK;
                        end
                    end
                end
                // escape limit sensor (2-sensor mode only), then 200 raw steps
                ST_BACK:
                begin
                    if (!cleared_q)
                    begin
                        if (!(limit_pos | limit_neg))
                            cleared_q <= 1'b1;
                    end
                    else if (backoff_q == BACKOFF_STEPS)
                        state_q <= ST_QUAL;
                    else if (step_en)
                        backoff_q <= backoff_q + 1'b1;
                end
                // continue until qualifiers seen, then offset
                ST_QUAL:
                begin
                    if (qual_ok &&
                        (home_mode != HOME_MODE_3SENSOR || home_sensor))
                    begin
                        dir_out  <= ~abs_neg;
                        remain_q <= abs_neg ? -home_offset : home_offset;
                        state_q  <= ST_OFFSET;
                    end
                end
                // offset move, then position is zero
                ST_OFFSET:
                begin
                    if (remain_q == '0)
                    begin
                        home_done_output <= 1'b1;
                        motor_current    <= stop_current;
                        state_q          <= ST_HOLD;
                    end
                    else if (step_en)
                        remain_q <= remain_q - 1'b1;
                end
                // ready again once start released
                ST_HOLD:
                begin
                    if (!start && !home_start)
                    begin
                        ready            <= 1'b1;
                        data_error_alarm <= 1'b0;
                        state_q          <= ST_IDLE;
                    end
                end
                default:
                    state_q <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // command position tracking
    // ------------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!nrst)
            command_position <= HOME_POS_ZERO;
        else if (state_q == ST_OFFSET && remain_q == '0)
            command_position <= HOME_POS_ZERO;
        else if (state_q == ST_IDLE && position_load_input)
            command_position <= preset_position;
        else if (step_en && running)
            command_position <= dir_out ? command_position + 1'b1
                                        : command_position - 1'b1;
    end

    // ------------------------------------------------------------------
    // step output register
    // ------------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (!nrst)
            step_out <= 1'b0;
        else
            step_out <= step_en && running;
    end

endmodule

// ### hw/motion_pkg.sv
package motion_pkg;

    // ------------------------------------------------------------------
    // widths
    // ------------------------------------------------------------------
    localparam int POS_W   = 24;   // signed position width in steps
    localparam int SPD_W   = 20;   // speed value width (steps per second)
    localparam int CUR_W   = 10;   // current setting width
    localparam int SEL_W   = 6;    // operation data select width

    // ------------------------------------------------------------------
    // homing modes and fixed figures
    // ------------------------------------------------------------------
    localparam logic [1:0] HOME_MODE_2SENSOR = 2'h0; // limit sensors only
    localparam logic [1:0] HOME_MODE_3SENSOR = 2'h1; // home sensor
    localparam logic [1:0] HOME_MODE_PUSH    = 2'h2; // mechanical stop
    localparam logic [1:0] HOME_MODE_RESET   = 2'h1; // default mode
    localparam logic [8:0] BACKOFF_STEPS     = 9'h0C8; // 200 steps
    localparam int         PUSH_MAX_RPM      = 30;   // push speed cap
    localparam int         SECS_PER_MIN      = 60;
    localparam logic [POS_W-1:0] HOME_POS_ZERO = 24'h000000;

    // ------------------------------------------------------------------
    // operation functions of a data entry
    // ------------------------------------------------------------------
    localparam logic [1:0] FUNC_SINGLE = 2'h0; // single motion
    localparam logic [1:0] FUNC_LINKED = 2'h1; // linked motion
    localparam logic [1:0] FUNC_PUSH   = 2'h2; // push motion

    // ------------------------------------------------------------------
    // step generator timing
    // ------------------------------------------------------------------
    localparam int CLK_HZ = 200000000; // 200 MHz core clock

endpackage

// ### hw/step_rate_gen.sv
`timescale 1ns/100ps
// produces one-cycle step enables at a programmable rate
module step_rate_gen
    import motion_pkg::*;
(
    input  wire logic             clock,    // core clock
    input  wire logic             nrst,     // sync reset, active low
    input  wire logic             run,      // generate steps while high
    input  wire logic [SPD_W-1:0] rate_hz,  // steps per second
    output logic                  step_en   // one-cycle step pulse
);

    // ------------------------------------------------------------------
    // phase accumulator
    // ------------------------------------------------------------------
    logic [31:0] acc_q;   // fractional step phase
    logic [32:0] sum;     // phase plus increment

    assign sum = {1'b0, acc_q} + {13'h0000, rate_hz};

    // accumulate rate each cycle; wrap past clock rate gives a step
    always_ff @(posedge clock)
    begin
        if (!nrst || !run)
        begin
            acc_q   <= 32'h00000000;
            step_en <= 1'b0;
        end
        else if (sum >= 33'(CLK_HZ))
        begin
            acc_q   <= 32'(sum - 33'(CLK_HZ));
            step_en <= 1'b1;
        end
        else
        begin
            acc_q   <= sum[31:0];
            step_en <= 1'b0;
        end
    end

endmodule

// ### dv/push_home_checker_asserts.sv
`timescale 1ns/100ps
// watches the top module ports of the push and homing controller
module push_home_checker
    import motion_pkg::*;
(
    input  wire logic             clock,               // core clock
    input  wire logic             nrst,                // sync reset
    input  wire logic             start,               // entry start
    input  wire logic             home_start,          // homing start
    input  wire logic             ready,               // ready out
    input  wire logic [1:0]       entry_func,          // entry function
    input  wire logic [SPD_W-1:0] entry_speed,         // entry speed
    input  wire logic [15:0]      steps_per_rev,       // resolution
    input  wire logic             data_error_alarm,    // data alarm
    input  wire logic             step_out,            // step pulse
    input  wire logic             push_contact_flag,   // push status
    input  wire logic             op_complete_output,  // op ended
    input  wire logic             home_done_output,    // homed
    input  wire logic             stop_in,             // stop request
    input  wire logic             position_load_input, // preset load
    input  wire logic [CUR_W-1:0] motor_current,       // current out
    input  wire logic [CUR_W-1:0] push_current,        // push setting
    input  wire logic [CUR_W-1:0] stop_current,        // stop setting
    input  wire logic [POS_W-1:0] preset_position,     // preset value
    input  wire logic [POS_W-1:0] command_position     // position
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    logic fast; // push speed above half a turn per second
    assign fast = (entry_func == FUNC_PUSH)
                  && ({entry_speed, 1'b0} > {5'h00, steps_per_rev});

    chk_start_taken: assert property ($rose(start) && ready && !fast
        |=> !ready) else $error("start not taken");
    chk_home_taken: assert property ($rose(home_start) && ready
        |=> !ready) else $error("homing start not taken");
    chk_alarm_fast: assert property ($rose(start) && ready && fast
        |-> ##[1:2] data_error_alarm) else $error("no speed alarm");
    chk_alarm_still: assert property (data_error_alarm
        |-> !step_out) else $error("step during alarm");
    chk_contact_cur: assert property ($rose(push_contact_flag)
        |-> motor_current == push_current) else $error("push current");
    chk_contact_rdy: assert property ($rose(push_contact_flag)
        && !start |-> ##[0:2] ready) else $error("no ready at push");
    chk_start_clear: assert property ($rose(start) && ready && !fast
        |=> !push_contact_flag && !op_complete_output)
        else $error("stale status");
    chk_stop_cur: assert property ($rose(op_complete_output) && stop_in
        |-> motor_current == stop_current) else $error("stop current");
    chk_home_zero: assert property ($rose(home_done_output)
        |-> command_position == HOME_POS_ZERO) else $error("home not 0");
    chk_preset_ld: assert property (ready && position_load_input
        && !start && !home_start |=> !step_out
        && command_position == $past(preset_position)) else $error("preset");

    cover property ($rose(push_contact_flag));
    cover property ($rose(home_done_output));
    cover property ($rose(data_error_alarm));
endmodule

bind push_home_ctrl push_home_checker chk_u (.*);

// ### dv/host_model.sv
`timescale 1ns/100ps
// host side: selects an entry and runs the start handshake
module host_model
    import motion_pkg::*;
(
    input  wire logic             clock,              // core clock
    input  wire logic             ready,              // device ready
    output logic [SEL_W-1:0]      data_select_inputs, // entry number
    output logic                  start,              // entry start
    output logic                  home_start          // homing start
);
    initial
    begin
        data_select_inputs = 6'h00;
        start = 1'b0;
        home_start = 1'b0;
    end

    // one request, all changes on falling edges
    task automatic request(input logic home, input logic [SEL_W-1:0] sel);
        int n = 0;
        while (ready !== 1'b1 && n < 60000)
        begin
            @(negedge clock);
            n++;
        end
        data_select_inputs = sel; // settle select first
        @(negedge clock);
        start = !home;
        home_start = home;
        n = 0;
        while (ready !== 1'b0 && n < 8) // hold until ready drops
        begin
            @(negedge clock);
            n++;
        end
        start = 1'b0;
        home_start = 1'b0;
    endtask
endmodule

// ### dv/test_push_motion_and_homing_control.sv
`timescale 1ns/100ps
module test_push_motion_and_homing_control
    import motion_pkg::*;
;
    logic clock = 1'b0, nrst = 1'b0, stop_in = 1'b0, load_contact = 1'b0;
    logic position_load_input = 1'b0, entry_dir = 1'b1, home_dir = 1'b1;
    logic sensor_input_a_enable = 1'b1, tim_enable = 1'b0, home_sensor = 1'b0;
    logic limit_pos = 1'b0, limit_neg = 1'b0, sensor_input_a = 1'b0;
    logic timing_signal = 1'b0, saw_alarm = 1'b0;
    logic start, home_start, ready, push_contact_flag, op_complete_output;
    logic home_done_output, data_error_alarm, step_out, dir_out;
    logic [SEL_W-1:0] data_select_inputs, active_entry;
    logic [1:0] entry_func = FUNC_PUSH, next_func = FUNC_SINGLE;
    logic [1:0] home_mode = HOME_MODE_RESET;
    logic [SPD_W-1:0] entry_speed = 20'h07FEE, next_speed = 20'h07FEE;
    logic [SPD_W-1:0] home_run_speed = 20'hFFFFF;
    logic [SPD_W-1:0] home_start_speed = 20'hFFFFF;
    logic [POS_W-1:0] entry_dist = 24'h000064, next_dist = 24'h000064;
    logic [POS_W-1:0] home_offset = 24'h000000, preset_position = 24'h012345;
    logic [POS_W-1:0] command_position;
    logic [CUR_W-1:0] push_current = 10'h1F0, run_current = 10'h2A0;
    logic [CUR_W-1:0] stop_current = 10'h055, motor_current;
    logic [15:0] steps_per_rev = 16'hFFDC;
    int err_total = 0, cmp_count = 0, steps_n = 0;

    push_home_ctrl dut_u (.*);
    host_model host_u (.*);

    initial
    begin
        forever #2.5 clock = ~clock;
    end

    // step counter and sticky alarm monitor
    always @(posedge clock)
    begin
        if (step_out === 1'b1) steps_n <= steps_n + 1;
        if (data_error_alarm === 1'b1) saw_alarm <= 1'b1;
    end

    task automatic chk(input logic [POS_W-1:0] seen, exp);
        cmp_count++;
        if (seen !== exp)
        begin
            err_total++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wait_rdy(input logic lvl);
        int n = 0;
        while (ready !== lvl && n < 60000)
        begin
            @(negedge clock);
            n++;
        end
    endtask

    task automatic wait_steps(input int k);
        int n = 0;
        while (steps_n < k && n < 9000)
        begin
            @(negedge clock);
            n++;
        end
    endtask

    task automatic s_contact();
        host_u.request(1'b0, 6'h01);
        load_contact = 1'b1;
        wait_rdy(1'b1);
        chk(24'(push_contact_flag), 24'h1);
        chk(24'(motor_current), 24'(push_current));
        chk(24'(active_entry), 24'h1);
        load_contact = 1'b0;
    endtask

    task automatic s_plain();
        entry_dist = 24'h000001;
        host_u.request(1'b0, 6'h02);
        wait_rdy(1'b1);
        chk(24'(push_contact_flag), 24'h0);
        chk(24'(op_complete_output), 24'h1);
        chk(24'(motor_current), 24'(push_current));
    endtask

    task automatic s_stop();
        entry_dist = 24'h000400;
        entry_dir = 1'b0;
        host_u.request(1'b0, 6'h03);
        stop_in = 1'b1;
        wait_rdy(1'b1);
        chk(24'(op_complete_output), 24'h1);
        chk(24'(motor_current), 24'(stop_current));
        stop_in = 1'b0;
        entry_dir = 1'b1;
    endtask

    task automatic s_fast();
        entry_speed = 20'h07FEF;
        steps_n = 0;
        saw_alarm = 1'b0;
        host_u.request(1'b0, 6'h04);
        wait_rdy(1'b1);
        chk(24'(saw_alarm), 24'h1);
        chk(24'(steps_n), 24'h0);
        entry_speed = 20'h07FEE;
    endtask

    task automatic s_linked();
        entry_func = FUNC_LINKED;
        next_func = FUNC_PUSH;
        entry_speed = 20'hFFFFF;
        entry_dist = 24'h000002;
        steps_n = 0;
        host_u.request(1'b0, 6'h05);
        wait_steps(3);
        chk(24'(ready), 24'h0);
        load_contact = 1'b1;
        wait_rdy(1'b1);
        chk(24'(push_contact_flag), 24'h1);
        load_contact = 1'b0;
        entry_func = FUNC_PUSH;
        entry_speed = 20'h07FEE;
    endtask

    // seek, trip the mode's sensor, count steps after release
    task automatic s_home(input logic [1:0] m, input int exp_n);
        int n = 0;
        home_mode = m;
        home_dir = (m != HOME_MODE_2SENSOR);
        steps_n = 0;
        host_u.request(1'b1, 6'h00);
        wait_steps(2);
        home_sensor = (m == HOME_MODE_3SENSOR);
        limit_neg = (m == HOME_MODE_2SENSOR);
        load_contact = (m == HOME_MODE_PUSH);
        while (m != HOME_MODE_3SENSOR && dir_out === home_dir && n < 9000)
        begin
            @(negedge clock);
            n++;
        end
        limit_neg = 1'b0;
        load_contact = 1'b0;
        steps_n = 0;
        wait_steps(1);
        sensor_input_a = 1'b1;
        wait_rdy(1'b1);
        chk(24'(steps_n), 24'(exp_n));
        chk(24'(home_done_output), 24'h1);
        chk(command_position, HOME_POS_ZERO);
        home_sensor = 1'b0;
    endtask

    task automatic s_preset();
        steps_n = 0;
        position_load_input = 1'b1;
        @(negedge clock);
        position_load_input = 1'b0;
        @(negedge clock);
        chk(command_position, preset_position);
        chk(24'(steps_n), 24'h0);
    endtask

    task automatic stop_test();
        if (err_total == 0 && cmp_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // main sequence
    initial
    begin
        repeat (3) @(negedge clock);
        nrst = 1'b1;
        @(negedge clock);
        s_contact();
        s_plain();
        s_stop();
        s_fast();
        s_linked();
        home_offset = 24'h000005;
        s_home(HOME_MODE_3SENSOR, 6);
        home_offset = 24'h000000;
        s_home(HOME_MODE_2SENSOR, 200);
        s_home(HOME_MODE_PUSH, 200);
        s_preset();
        stop_test();
    end

    // watchdog a little past the expected run length
    initial
    begin
        #500000;
        err_total++;
        stop_test();
    end
endmodule
